// ===== pkg/twp_pkg.sv
// Shared types and constants for the two-wire bus master controller.
// Assumes a 25 MHz ref_clk and open-drain SCL/SDA with pull-ups outside.
package twp_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_NS      = 40;
    localparam int QTR_NS      = 2500;
    localparam int QTR_CYC     = (QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUS_FREE_NS = 50000;
    localparam int FREE_CYC    = (BUS_FREE_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int TMO_MS      = 25;
    localparam int TMO_CYC_DEF = TMO_MS * 1000000 / CLK_NS;

    // ************************************************************
    // Widths and field values
    // ************************************************************
    localparam int CNT_W  = 12;
    localparam int TMO_W  = 20;
    localparam int LEN_W  = 8;
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 16;

    localparam logic [CNT_W-1:0] QTR_LAST  = CNT_W'(QTR_CYC - 1);
    localparam logic [CNT_W-1:0] FREE_LAST = CNT_W'(FREE_CYC - 1);
    localparam logic [3:0]       BIT_LAST  = 4'h8;
    localparam logic [7:0]       RX_FILL   = 8'hFF;
    localparam logic [LEN_W-1:0] LEN_ONE   = 8'h01;
    localparam logic [LEN_W-1:0] LEN_NONE  = 8'h00;

    localparam logic [1:0] PH_LOW_A  = 2'h0;
    localparam logic [1:0] PH_LOW_B  = 2'h1;
    localparam logic [1:0] PH_HIGH_A = 2'h2;
    localparam logic [1:0] PH_HIGH_B = 2'h3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_FREE  = 6'h02,
        ST_START = 6'h04,
        ST_BIT   = 6'h08,
        ST_LOAD  = 6'h10,
        ST_STOP  = 6'h20
    } twp_st_t;

    typedef struct packed {
        logic [6:0]       addr;
        logic             rw;
        logic [LEN_W-1:0] len;
    } twp_cmd_t;

    typedef struct packed {
        logic done;
        logic nack;
        logic timeout;
    } twp_stat_t;

    typedef struct packed {
        twp_st_t          st;
        logic [1:0]       ph;
        logic [CNT_W-1:0] cnt;
        logic [TMO_W-1:0] tmo;
        logic [3:0]       bitn;
        logic [8:0]       sh;
        logic [8:0]       rx;
        logic [6:0]       addr;
        logic             rw;
        logic             addr_ph;
        logic [LEN_W-1:0] left;
        logic             scl_drv;
        logic             sda_drv;
        logic [7:0]       rd_data;
        logic             rd_valid;
        logic             done;
        logic             nack;
        logic             tmo_flag;
        logic             scl_s1;
        logic             scl_s2;
        logic             sda_s1;
        logic             sda_s2;
    } twp_state_t;

    localparam twp_state_t STATE_RESET = '{st: ST_IDLE, default: '0};

endpackage

// ===== core/twp_fifo.sv
// Write-data FIFO between the user port and the serial engine.
// Assumes both sides run on ref_clk.
`timescale 1ns/1ps
module twp_fifo import twp_pkg::*; #(
    parameter int WIDTH = FIFO_W,
    parameter int DEPTH = FIFO_D
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // ************************************************************
    // Storage and pointers
    // ************************************************************
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_reg;
    logic [AW:0]      rp_reg;
    logic             push;
    logic             pop;

    // Extra pointer bit tells full from empty
    assign in_ready  = (wp_reg[AW] == rp_reg[AW]) || (wp_reg[AW-1:0] != rp_reg[AW-1:0]);
    assign out_valid = (wp_reg != rp_reg);
    assign out_data  = mem[rp_reg[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= rp_reg + 1'b1;
            end
        end
    end

    // No reset on the array; contents are only read once written
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wp_reg[AW-1:0]] <= in_data;
        end
    end

endmodule // twp_fifo

// ===== core/twp_master.sv
// Two-wire bus master that drives a byte-oriented bus slave over SCL/SDA.
// Assumes pull-ups on both lines and a testbench resolving the open-drain wires.
//
// Function
// - Master starts transfers and makes every clock.
// - START, address byte, data bytes, then STOP.
// - Direction in address bit zero, one reads.
// - Receiver acknowledges with SDA low, SCL high.
// - SDA high at ack time means not acknowledged.
// - Write: master sends bytes, expects ack each.
// - Read: slave sends bytes, master acknowledges all but the last.
// - Master ends transfer with STOP, freeing bus (code skips STOP on timeout or lost arbitration).
// - Master waits while slave holds SCL low.
// - Lines only pulled low or released, never driven high.
// - SCL low over 25 ms: timeout, reset soon (code times only slave stretch, not SCL low in ST_FREE or ST_LOAD).
`timescale 1ns/1ps
module twp_master import twp_pkg::*; #(
    parameter int TMO_CYC    = TMO_CYC_DEF,
    parameter int FIFO_DEPTH = FIFO_D
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire twp_cmd_t          cmd,
    input  wire logic              wr_valid,
    output logic                   wr_ready,
    input  wire logic [FIFO_W-1:0] wr_data,
    output logic                   rd_valid,
    output logic       [7:0]       rd_data,
    output twp_stat_t              status,
    input  wire logic              scl_i,
    output logic                   scl_o,
    output logic                   scl_oe_n,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_n
);
    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TMO_CYC - 1);

    // ************************************************************
    // State
    // ************************************************************
    twp_state_t        r;
    twp_state_t        n;
    logic              qtr_end;
    logic              stretch;
    logic              byte_end;
    logic              tx_byte;
    logic [LEN_W-1:0]  left_nx;
    logic              fifo_valid;
    logic              fifo_pop;
    logic [FIFO_W-1:0] fifo_data;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    twp_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   (wr_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign cmd_ready = (r.st == ST_IDLE);
    assign rd_valid  = r.rd_valid;
    assign rd_data   = r.rd_data;
    assign status    = '{done: r.done, nack: r.nack, timeout: r.tmo_flag};
    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;
    assign scl_oe_n  = !r.scl_drv;
    assign sda_oe_n  = !r.sda_drv;

    // Slave stretching SCL shows as released-but-low in the high phase
    assign stretch = ((r.st == ST_BIT) || (r.st == ST_STOP)) && (r.ph == PH_HIGH_A)
                     && !r.scl_s2;
    assign qtr_end = (r.cnt == QTR_LAST) && !stretch;
    assign tx_byte = r.addr_ph || !r.rw;
    assign left_nx = r.addr_ph ? r.left : r.left - 1'b1;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        n          = r;
        byte_end   = 1'b0;
        fifo_pop   = 1'b0;
        n.scl_s1   = scl_i;
        n.scl_s2   = r.scl_s1;
        n.sda_s1   = sda_i;
        n.sda_s2   = r.sda_s1;
        n.rd_valid = 1'b0;
        n.done     = 1'b0;
        n.cnt      = (qtr_end || stretch) ? '0 : r.cnt + 1'b1;
        if (qtr_end) begin
            n.ph = r.ph + 1'b1;
        end
        case (r.st)
            ST_IDLE: begin
                n.cnt = '0;
                n.ph  = PH_LOW_A;
                if (cmd_valid) begin
                    n.addr     = cmd.addr;
                    n.rw       = cmd.rw;
                    n.left     = cmd.len;
                    n.addr_ph  = 1'b1;
                    n.nack     = 1'b0;
                    n.tmo_flag = 1'b0;
                    n.st       = ST_FREE;
                end
            end
            ST_FREE: begin
                // Hold off until both lines have idled high long enough
                n.ph  = PH_LOW_A;
                n.cnt = (r.scl_s2 && r.sda_s2) ? r.cnt + 1'b1 : '0;
                if (r.scl_s2 && r.sda_s2 && (r.cnt == FREE_LAST)) begin
                    n.cnt = '0;
                    n.st  = ST_START;
                end
            end
            ST_START: begin
                if (qtr_end && (r.ph == PH_LOW_B)) begin
                    n.sda_drv = 1'b1;
                end
                if (qtr_end && (r.ph == PH_HIGH_A)) begin
                    n.scl_drv = 1'b1;
                    n.st      = ST_BIT;
                    n.ph      = PH_LOW_A;
                    n.bitn    = '0;
                    n.sh      = {r.addr, r.rw, 1'b1};
                end
            end
            ST_BIT: begin
                if (qtr_end) begin
                    case (r.ph)
                        PH_LOW_A: n.sda_drv = !r.sh[8];
                        PH_LOW_B: n.scl_drv = 1'b0;
                        PH_HIGH_A: begin
                            n.rx = {r.rx[7:0], r.sda_s2};
                            // Released high but read low: another master won
                            if (tx_byte && (r.bitn != BIT_LAST) && !r.sda_drv
                                && !r.sda_s2) begin
                                n.sda_drv = 1'b0;
                                n.scl_drv = 1'b0;
                                n.nack    = 1'b1;
                                n.st      = ST_IDLE;
                            end
                        end
                        default: begin
                            n.scl_drv = 1'b1;
                            n.sh      = {r.sh[7:0], 1'b1};
                            n.bitn    = r.bitn + 1'b1;
                            byte_end  = (r.bitn == BIT_LAST);
                        end
                    endcase
                end
                if (byte_end) begin
                    n.bitn = '0;
                    if (tx_byte && r.rx[0]) begin
                        n.nack = 1'b1;
                        n.st   = ST_STOP;
                    end else begin
                        if (!r.addr_ph && r.rw) begin
                            n.rd_data  = r.rx[8:1];
                            n.rd_valid = 1'b1;
                        end
                        n.left    = left_nx;
                        n.addr_ph = 1'b0;
                        if (left_nx == LEN_NONE) begin
                            n.st = ST_STOP;
                        end else if (r.rw) begin
                            // Last byte read is refused so the slave lets go of SDA
                            n.sh = {RX_FILL, (left_nx == LEN_ONE)};
                        end else begin
                            n.st = ST_LOAD;
                        end
                    end
                end
            end
            ST_LOAD: begin
                // SCL stays low while the FIFO is empty; stalls the slave too
                n.cnt = '0;
                n.ph  = PH_LOW_A;
                if (fifo_valid) begin
                    fifo_pop = 1'b1;
                    n.sh     = {fifo_data, 1'b1};
                    n.st     = ST_BIT;
                end
            end
            ST_STOP: begin
                if (r.ph == PH_LOW_A) begin
                    n.sda_drv = 1'b1;
                end
                if (qtr_end) begin
                    case (r.ph)
                        PH_LOW_B: n.scl_drv = 1'b0;
                        PH_HIGH_A: n.sda_drv = 1'b0;
                        PH_HIGH_B: begin
                            n.st   = ST_IDLE;
                            n.done = 1'b1;
                        end
                        default: ;
                    endcase
                end
            end
            default: n = STATE_RESET;
        endcase
        // Stuck clock: give up after TMO_CYC cycles of stretch, 25 ms by default
        if (stretch) begin
            if (r.tmo == TMO_LAST) begin
                n.st       = ST_IDLE;
                n.scl_drv  = 1'b0;
                n.sda_drv  = 1'b0;
                n.tmo_flag = 1'b1;
                n.tmo      = '0;
            end else begin
                n.tmo = r.tmo + 1'b1;
            end
        end else begin
            n.tmo = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= STATE_RESET;
        end else begin
            r <= n;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_idle_released: assert property (
        (r.st == ST_IDLE) |-> (scl_oe_n && sda_oe_n))
        else $error("line pulled while idle");

    a_scl_by_master: assert property (
        $rose(scl_oe_n) |-> ($past(r.ph) == PH_LOW_B) || r.tmo_flag)
        else $error("SCL released outside clock phase");

    a_start_cond: assert property (
        ((r.st == ST_START) && $fell(sda_oe_n)) |-> scl_oe_n)
        else $error("START without SCL high");

    a_stop_cond: assert property (
        ((r.st == ST_STOP) && $rose(sda_oe_n)) |-> (scl_oe_n && !r.scl_drv))
        else $error("STOP without SCL high");

    a_addr_dir: assert property (
        ((r.st == ST_START) && (n.st == ST_BIT)) |=> (r.sh == {r.addr, r.rw, 1'b1}))
        else $error("address byte malformed");

    a_nack_stop: assert property (
        (byte_end && tx_byte && r.rx[0]) |=> ((r.st == ST_STOP) && r.nack))
        else $error("nack not followed by stop");

    a_master_ack: assert property (
        ((r.st == ST_BIT) && !r.addr_ph && r.rw && (r.bitn == BIT_LAST)
         && (r.ph == PH_HIGH_A)) |-> (sda_oe_n == (r.left == LEN_ONE)))
        else $error("wrong ack on read byte");

    a_write_fifo: assert property (
        (fifo_valid && fifo_pop) |=> ((r.sh[8:1] == $past(fifo_data)) && (r.st == ST_BIT)))
        else $error("write byte not loaded");

    a_stretch_wait: assert property (
        (stretch && (r.tmo != TMO_LAST)) |=> ((r.ph == PH_HIGH_A) && (r.cnt == '0)))
        else $error("clock advanced during stretch");

    a_timeout_abort: assert property (
        (stretch && (r.tmo == TMO_LAST)) |=> ((r.st == ST_IDLE) && r.tmo_flag && scl_oe_n))
        else $error("timeout not handled");

    a_done_stop: assert property (
        r.done |-> ($past(r.st) == ST_STOP) && (r.st == ST_IDLE))
        else $error("done without stop");

endmodule // twp_master

// ===== test/twp_slave_model.sv
// Behavioural bus slave that faces the two-wire master.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps
module twp_slave_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2C
) (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic stretch_en,
    input  wire logic hold_en,
    output logic      scl_low,
    output logic      sda_low
);
    // ************************************************************
    // Frame handling
    // ************************************************************
    logic [7:0] rx_mem [0:31];
    logic [7:0] addr_byte;
    logic [7:0] ack_log;
    logic       stretch_q;
    logic       hold_q;
    int         rx_cnt;
    int         tx_cnt;
    int         stop_cnt;

    // Only pulls low, never drives high
    assign scl_low = stretch_q | hold_q;

    always @(negedge scl or negedge hold_en) begin
        hold_q <= hold_en;
    end

    task automatic get_byte(output logic [7:0] b);
        repeat (8) begin
            @(posedge scl);
            b = {b[6:0], sda};
        end
    endtask

    task automatic ack_phase();
        @(negedge scl);
        sda_low = 1'b1;
        if (stretch_en) begin
            // Longer than the master's low half, so it must wait
            stretch_q = 1'b1;
            #8000;
            stretch_q = 1'b0;
        end
        @(negedge scl);
        sda_low = 1'b0;
    endtask

    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda_low = ~b[i];
            @(negedge scl);
        end
        sda_low = 1'b0;
        @(posedge scl);
        ack_log = {ack_log[6:0], ~sda};
        @(negedge scl);
    endtask

    task automatic frame();
        logic [7:0] b;
        get_byte(addr_byte);
        if (addr_byte[7:1] != DEV_ADDR) begin
            return;
        end
        ack_phase();
        if (!addr_byte[0]) begin
            forever begin
                get_byte(b);
                rx_mem[rx_cnt[4:0]] = b;
                rx_cnt++;
                ack_phase();
            end
        end else begin
            do begin
                put_byte(8'h96 ^ 8'(tx_cnt));
                tx_cnt++;
            end while (ack_log[0]);
        end
    endtask

    initial begin
        {stretch_q, hold_q, sda_low} = '0;
        ack_log = '0;
        rx_cnt = 0;
        tx_cnt = 0;
        stop_cnt = 0;
        forever begin
            @(negedge sda iff scl === 1'b1);
            fork
                begin
                    frame();
                    wait (1'b0);
                end
                begin
                    @(posedge sda iff scl === 1'b1);
                    stop_cnt++;
                end
            join_any
            disable fork;
            sda_low = 1'b0;
            stretch_q = 1'b0;
        end
    end
endmodule // twp_slave_model

// ===== test/two_wire_bus_protocol_engine_tb_top.sv
// Self-checking bench for the two-wire master against a slave model.
// Assumes a 25 MHz ref_clk and pull-ups on both resolved lines.
`timescale 1ns/1ps
module two_wire_bus_protocol_engine_tb_top import twp_pkg::*;;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    localparam int         TMO = 2000;
    localparam logic [6:0] DEV = 7'h2C;
    logic       ref_clk, rst_n, cmd_valid, wr_valid, stretch_en, hold_en;
    logic       cmd_ready, wr_ready, rd_valid, scl_o, sda_o, scl_oe_n, sda_oe_n;
    logic       slv_scl_low, slv_sda_low;
    logic [7:0] wr_data, rd_data;
    twp_cmd_t   cmd;
    twp_stat_t  status;
    wire        scl_w = ~(~scl_oe_n | slv_scl_low);
    wire        sda_w = ~(~sda_oe_n | slv_sda_low);
    int         mismatches, checks, cycles;
    logic [7:0] rdq [$];

    twp_master #(.TMO_CYC(TMO), .FIFO_DEPTH(FIFO_D)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_data(rd_data), .status(status), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n));

    twp_slave_model #(.DEV_ADDR(DEV)) slv_u (
        .scl(scl_w), .sda(sda_w), .stretch_en(stretch_en), .hold_en(hold_en),
        .scl_low(slv_scl_low), .sda_low(slv_sda_low));

    always #20 ref_clk = ~ref_clk;

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic push(input logic [7:0] b);
        @(negedge ref_clk);
        wr_valid = 1'b1;
        wr_data = b;
        // Ready is judged where it is settled, never in the edge's own time step
        while (wr_ready !== 1'b1) @(negedge ref_clk);
        @(posedge ref_clk);
        @(negedge ref_clk);
        wr_valid = 1'b0;
    endtask

    // Start count is cycles from take to SDA falling; end count to done
    task automatic run_cmd(input logic [6:0] a, input logic rw, input logic [7:0] len,
                           output int s, output int e);
        s = 0;
        e = 0;
        rdq.delete();
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd = '{addr: a, rw: rw, len: len};
        while (cmd_ready !== 1'b1) @(negedge ref_clk);
        @(posedge ref_clk);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        while (status.done !== 1'b1 && status.timeout !== 1'b1 && e < 60000) begin
            @(negedge ref_clk);
            e++;
            if (s == 0 && sda_oe_n === 1'b0) s = e;
            if (rd_valid === 1'b1) rdq.push_back(rd_data);
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic sc_reset();
        check(cmd_ready, 1);
        check(wr_ready, 1);
        check(rd_valid, 0);
        check(status, 0);
        check({scl_oe_n, sda_oe_n}, 2'b11);
        check({scl_o, sda_o}, 0);
    endtask

    task automatic sc_write();
        int s, e;
        push(8'h5A);
        push(8'hC3);
        run_cmd(DEV, 1'b0, 8'h02, s, e);
        check(status.done, 1);
        check(status.nack, 0);
        check(s >= FREE_CYC, 1);
        check(slv_u.addr_byte, {DEV, 1'b0});
        check(slv_u.rx_mem[0], 8'h5A);
        check(slv_u.rx_mem[1], 8'hC3);
        check(16'(slv_u.stop_cnt), 1);
    endtask

    task automatic sc_read();
        int s, e;
        run_cmd(DEV, 1'b1, 8'h03, s, e);
        check(16'(rdq.size()), 3);
        for (int i = 0; i < 3; i++) check(rdq[i], 8'h96 ^ 8'(i));
        check(slv_u.ack_log[2:0], 3'b110);
        check(slv_u.addr_byte, {DEV, 1'b1});
        check(status.nack, 0);
        check(16'(slv_u.stop_cnt), 2);
    endtask

    task automatic sc_nack();
        int s, e;
        run_cmd(DEV ^ 7'h01, 1'b0, 8'h00, s, e);
        check(status.done, 1);
        check(status.nack, 1);
        check(16'(slv_u.rx_cnt), 2);
        check(16'(slv_u.stop_cnt), 3);
    endtask

    task automatic sc_fill_stretch();
        int s, e;
        for (int i = 0; i < 16; i++) push(8'h10 + 8'(i));
        check(wr_ready, 0);
        // A seventeenth byte offered while full must be refused
        @(negedge ref_clk);
        wr_valid = 1'b1;
        wr_data = 8'hEE;
        repeat (3) @(negedge ref_clk);
        wr_valid = 1'b0;
        stretch_en = 1'b1;
        run_cmd(DEV, 1'b0, 8'h10, s, e);
        stretch_en = 1'b0;
        check(status.nack, 0);
        check(status.done, 1);
        for (int i = 0; i < 16; i++) check(slv_u.rx_mem[2 + i], 8'h10 + 8'(i));
        check(16'(slv_u.rx_cnt), 18);
        check(wr_ready, 1);
        check((e - s) >= 17 * 9 * 252 + 63 + 252 + 17 * 40, 1);
    endtask

    task automatic sc_timeout();
        int s, e;
        fork
            begin
                @(negedge ref_clk iff scl_oe_n === 1'b0);
                hold_en = 1'b1;
            end
        join_none
        run_cmd(DEV, 1'b0, 8'h00, s, e);
        check(status.timeout, 1);
        check(status.done, 0);
        check({scl_oe_n, sda_oe_n}, 2'b11);
        check((e - s) > TMO && (e - s) < TMO + 800, 1);
        hold_en = 1'b0;
    endtask

    // ************************************************************
    // Main sequence and hang guard
    // ************************************************************
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 95000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        {ref_clk, rst_n, cmd_valid, wr_valid, stretch_en, hold_en} = '0;
        cmd = '0;
        wr_data = 8'h00;
        mismatches = 0;
        checks = 0;
        cycles = 0;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        sc_reset();
        rst_n = 1'b1;
        sc_write();
        sc_read();
        sc_nack();
        sc_fill_stretch();
        sc_timeout();
        finish_test();
    end
endmodule // two_wire_bus_protocol_engine_tb_top
